// >>> dscg_top.sv
// Deep-sleep module clock gating with run and sleep companions, APB slave
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
// Overview of operation
// RQ1 - Gate bit one clocks and enables its module; zero stops and disables it.
// RQ2 - Access to a module whose clock is off answers with a bus fault.
// RQ3 - Reset clears every gate word to zero; all modules start unclocked.
// RQ4 - Deep-sleep gate word sits at byte offset 0x124.
// RQ5 - Separate gate words exist for run, sleep and deep sleep.
// RQ6 - Sleep words govern only with automatic gating set; else run word governs.
// RQ7 - Unused bits are read-only zero; writes to them do nothing.
// RQ8 - Software preserves unused bits by read-modify-write.
// RQ9 - Software enables each needed module before touching it.
// RQ10 - Bit 16 gates timer zero, read/write.
// RQ11 - Bit 17 gates timer one, read/write.
// RQ12 - Bit 12 gates two-wire serial zero, read/write.
// RQ13 - Bit 4 gates synchronous serial zero, read/write.
// RQ14 - Bit 1 gates asynchronous serial one, read/write.
// RQ15 - Bit 0 gates asynchronous serial zero, read/write.
// RQ16 - Bit 24 gates comparator zero, read/write.
// RQ17 - Bit 18 gates timer two, read/write.
// RQ18 - Clock enables change only on system clock edges, never glitching.
module dscg_top #(
  parameter int unsigned NUM_MOD = dscg_pkg::NUM_MODULES
) (
  // Clock and reset
  input  wire logic                  I_CLK,
  input  wire logic                  I_RESET,
  // APB slave
  input  wire logic                  I_PSEL,
  input  wire logic                  I_PENABLE,
  input  wire logic                  I_PWRITE,
  input  wire logic [11:0]           I_PADDR,
  input  wire logic [31:0]           I_PWDATA,
  output logic                       O_PREADY,
  output logic [31:0]                O_PRDATA,
  output logic                       O_PSLVERR,
  // Power mode from the processor
  input  wire logic                  I_SLEEP,
  input  wire logic                  I_DEEP_SLEEP,
  // Peripheral access watch, one bit per module
  input  wire logic [NUM_MOD-1:0]    I_MODULE_ACCESS,
  output logic                       O_BUS_FAULT,
  // Module clock enables and enables
  output logic [NUM_MOD-1:0]         O_CLK_EN,
  output logic [NUM_MOD-1:0]         O_MODULE_EN
);

  logic [31:0]          run_gate_word_reg;
  logic [31:0]          sleep_gate_word_reg;
  logic [31:0]          deep_sleep_gate_word_reg;
  logic [31:0]          run_clock_configuration_reg;
  logic [31:0]          active_word;
  logic [NUM_MOD-1:0]   clk_en_next;
  logic [NUM_MOD-1:0]   clk_en_reg;
  logic [NUM_MOD-1:0]   module_en_reg;
  logic                 bus_fault_reg;
  logic                 pready_reg;
  logic                 pslverr_reg;
  logic                 pslverr_next;
  logic [31:0]          prdata_reg;
  logic [31:0]          prdata_next;
  logic                 auto_clock_gating_select;
  logic                 access_done;
  dscg_pkg::dscg_mode_e mode;
  dscg_pkg::dscg_apb_req_s req;

  assign req.addr  = I_PADDR;
  assign req.write = I_PWRITE;
  assign req.wdata = I_PWDATA;

  // Write commits only at the access edge that sees pready high
  assign access_done = I_PSEL & I_PENABLE & pready_reg;

  assign auto_clock_gating_select = run_clock_configuration_reg[dscg_pkg::BIT_AUTO_CLOCK_GATING];

  // Deep sleep outranks sleep when both are signalled
  always_comb
  begin
    if (!auto_clock_gating_select)
      mode = dscg_pkg::DSCG_MODE_RUN; // [RQ6]
    else if (I_DEEP_SLEEP)
      mode = dscg_pkg::DSCG_MODE_DEEP;
    else if (I_SLEEP)
      mode = dscg_pkg::DSCG_MODE_SLEEP;
    else
      mode = dscg_pkg::DSCG_MODE_RUN;
  end

  always_comb
  begin
    case (mode)
      dscg_pkg::DSCG_MODE_RUN:   active_word = run_gate_word_reg; // [RQ5]
      dscg_pkg::DSCG_MODE_SLEEP: active_word = sleep_gate_word_reg; // [RQ5]
      dscg_pkg::DSCG_MODE_DEEP:  active_word = deep_sleep_gate_word_reg; // [RQ5]
      default:                   active_word = run_gate_word_reg;
    endcase
  end

  // Per-module enable taken from its gate bit
  genvar g;
  generate
    for (g = 0; g < NUM_MOD; g++)
    begin : gen_module
      // Positions 0,1,4,12,16,17,18,24 [RQ10] [RQ11] [RQ12] [RQ13] [RQ14] [RQ15] [RQ16] [RQ17]
      assign clk_en_next[g] = active_word[dscg_pkg::MODULE_BIT[g]]; // [RQ1]
    end
  endgenerate

  // Enables are flopped so a downstream gate cell only sees edge-aligned changes
  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
      clk_en_reg <= '0; // [RQ3]
    else
      clk_en_reg <= clk_en_next; // [RQ18]
  end

  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
      module_en_reg <= '0;
    else
      module_en_reg <= clk_en_next; // [RQ1]
  end

  // Fault judged against the enable the module really has right now
  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
      bus_fault_reg <= 1'b0;
    else
      bus_fault_reg <= |(I_MODULE_ACCESS & ~clk_en_reg); // [RQ2]
  end

  // Gate words; only writable bits are stored
  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
      run_gate_word_reg <= dscg_pkg::GATE_RESET; // [RQ3]
    else if (access_done && req.write && req.addr == dscg_pkg::OFS_RUN_GATE)
      run_gate_word_reg <= req.wdata & dscg_pkg::GATE_WMASK; // [RQ7]
  end

  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
      sleep_gate_word_reg <= dscg_pkg::GATE_RESET; // [RQ3]
    else if (access_done && req.write && req.addr == dscg_pkg::OFS_SLEEP_GATE)
      sleep_gate_word_reg <= req.wdata & dscg_pkg::GATE_WMASK; // [RQ7]
  end

  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
      deep_sleep_gate_word_reg <= dscg_pkg::GATE_RESET; // [RQ3]
    else if (access_done && req.write && req.addr == dscg_pkg::OFS_DEEP_GATE) // [RQ4]
      deep_sleep_gate_word_reg <= req.wdata & dscg_pkg::GATE_WMASK; // [RQ7]
  end

  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
      run_clock_configuration_reg <= dscg_pkg::CFG_RESET;
    else if (access_done && req.write && req.addr == dscg_pkg::OFS_RUN_CLOCK_CFG)
      run_clock_configuration_reg <= req.wdata & dscg_pkg::CFG_WMASK;
  end

  // Read data and error decided in the setup cycle, so access needs no wait
  always_comb
  begin
    prdata_next  = 32'h0000_0000;
    pslverr_next = 1'b0;
    case (req.addr)
      dscg_pkg::OFS_RUN_CLOCK_CFG: prdata_next = run_clock_configuration_reg;
      dscg_pkg::OFS_RUN_GATE:      prdata_next = run_gate_word_reg;
      dscg_pkg::OFS_SLEEP_GATE:    prdata_next = sleep_gate_word_reg;
      dscg_pkg::OFS_DEEP_GATE:     prdata_next = deep_sleep_gate_word_reg; // [RQ4]
      dscg_pkg::OFS_GATE_STATUS:
      begin
        prdata_next = active_word & dscg_pkg::GATE_WMASK;
        prdata_next[dscg_pkg::BIT_STAT_SLEEP] = (mode == dscg_pkg::DSCG_MODE_SLEEP);
        prdata_next[dscg_pkg::BIT_STAT_DEEP]  = (mode == dscg_pkg::DSCG_MODE_DEEP);
        pslverr_next = req.write;
      end
      default:                     pslverr_next = 1'b1;
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
      pready_reg <= 1'b0;
    else
      pready_reg <= I_PSEL & ~I_PENABLE;
  end

  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else if (I_PSEL && !I_PENABLE)
    begin
      prdata_reg  <= req.write ? 32'h0000_0000 : prdata_next;
      pslverr_reg <= pslverr_next;
    end
    else if (access_done)
    begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
  end

  assign O_PREADY    = pready_reg;
  assign O_PRDATA    = prdata_reg;
  assign O_PSLVERR   = pslverr_reg;
  assign O_BUS_FAULT = bus_fault_reg;
  assign O_CLK_EN    = clk_en_reg;
  assign O_MODULE_EN = module_en_reg;

endmodule

// >>> dscg_pkg.sv
// Constants and types shared by the deep-sleep clock gating block
package dscg_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [11:0] OFS_RUN_CLOCK_CFG = 12'h060;
  localparam logic [11:0] OFS_RUN_GATE      = 12'h104;
  localparam logic [11:0] OFS_SLEEP_GATE    = 12'h114;
  localparam logic [11:0] OFS_DEEP_GATE     = 12'h124;
  localparam logic [11:0] OFS_GATE_STATUS   = 12'h128;

  // Gate word field positions
  localparam int unsigned BIT_ASYNC_SERIAL_ZERO = 0;
  localparam int unsigned BIT_ASYNC_SERIAL_ONE  = 1;
  localparam int unsigned BIT_SYNC_SERIAL_ZERO  = 4;
  localparam int unsigned BIT_TWO_WIRE_ZERO     = 12;
  localparam int unsigned BIT_TIMER_ZERO        = 16;
  localparam int unsigned BIT_TIMER_ONE         = 17;
  localparam int unsigned BIT_TIMER_TWO         = 18;
  localparam int unsigned BIT_COMPARATOR_ZERO   = 24;

  // Writable bits of every gate word; all others read zero
  localparam logic [31:0] GATE_WMASK = 32'h0107_1013;
  localparam logic [31:0] GATE_RESET = 32'h0000_0000;

  // Run clock configuration fields
  localparam int unsigned BIT_AUTO_CLOCK_GATING = 0;
  localparam logic [31:0] CFG_WMASK            = 32'h0000_0001;
  localparam logic [31:0] CFG_RESET            = 32'h0000_0000;

  // Status word fields
  localparam int unsigned BIT_STAT_SLEEP = 30;
  localparam int unsigned BIT_STAT_DEEP  = 31;

  // Number of gated modules
  localparam int unsigned NUM_MODULES = 8;

  // Gate bit position of each module, module index order
  localparam int unsigned MODULE_BIT [NUM_MODULES] = '{
    BIT_ASYNC_SERIAL_ZERO, BIT_ASYNC_SERIAL_ONE, BIT_SYNC_SERIAL_ZERO,
    BIT_TWO_WIRE_ZERO, BIT_TIMER_ZERO, BIT_TIMER_ONE, BIT_TIMER_TWO,
    BIT_COMPARATOR_ZERO};

  // Power mode that selects the governing gate word
  typedef enum logic [1:0] {
    DSCG_MODE_RUN,
    DSCG_MODE_SLEEP,
    DSCG_MODE_DEEP
  } dscg_mode_e;

  // One APB request, taken straight from the bus inputs
  typedef struct packed {
    logic [11:0] addr;
    logic        write;
    logic [31:0] wdata;
  } dscg_apb_req_s;

endpackage

// >>> dscg_checker.sv
// Bus and gating assertions for the clock gating block
`timescale 1ns/1ps
module dscg_checker #(
  parameter int unsigned NUM_MOD = 8
) (
  // Clock, reset and bus
  input wire logic               I_CLK,
  input wire logic               I_RESET,
  input wire logic               I_PSEL,
  input wire logic               I_PENABLE,
  input wire logic               I_PWRITE,
  input wire logic [11:0]        I_PADDR,
  input wire logic               O_PREADY,
  input wire logic [31:0]        O_PRDATA,
  input wire logic               O_PSLVERR,
  // Modes, accesses and enables
  input wire logic               I_SLEEP,
  input wire logic               I_DEEP_SLEEP,
  input wire logic [NUM_MOD-1:0] I_MODULE_ACCESS,
  input wire logic               O_BUS_FAULT,
  input wire logic [NUM_MOD-1:0] O_CLK_EN,
  input wire logic [NUM_MOD-1:0] O_MODULE_EN
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  logic setup;
  logic gated;
  assign setup = I_PSEL && !I_PENABLE;
  assign gated = |(I_MODULE_ACCESS & ~O_CLK_EN);
  a_ready_next: assert property (setup |=> O_PREADY) else $error("ready missing");
  a_unmapped_err: assert property (
    setup && !(I_PADDR inside {12'h060, 12'h104, 12'h114, 12'h124, 12'h128}) |=> O_PSLVERR && O_PRDATA == 32'h0)
    else $error("unmapped not refused");
  a_deep_mapped: assert property (setup && I_PADDR == 12'h124 |=> !O_PSLVERR) else $error("deep word refused");
  a_reserved_zero: assert property (
    setup && !I_PWRITE && I_PADDR == 12'h124 |=> (O_PRDATA & ~dscg_pkg::GATE_WMASK) == 32'h0)
    else $error("reserved bits set");
  a_fault_gated: assert property (gated |=> O_BUS_FAULT) else $error("fault missing");
  a_fault_clean: assert property (!gated |=> !O_BUS_FAULT) else $error("false fault");
  a_enable_pair: assert property (O_MODULE_EN == O_CLK_EN) else $error("enables differ");
  a_enable_cause: assert property (
    O_CLK_EN != $past(O_CLK_EN) |-> $past(I_PSEL && I_PENABLE && I_PWRITE, 2)
    || $past(I_SLEEP) != $past(I_SLEEP, 2) || $past(I_DEEP_SLEEP) != $past(I_DEEP_SLEEP, 2))
    else $error("enable changed without cause");
  a_reset_clear: assert property ($fell(I_RESET) |-> O_CLK_EN == '0 && !O_PREADY) else $error("not cleared");
  c_fault: cover property (O_BUS_FAULT);
  c_deep: cover property (I_DEEP_SLEEP && O_CLK_EN != '0);
  c_error: cover property (O_PREADY && O_PSLVERR);
endmodule
bind dscg_top dscg_checker #(.NUM_MOD(NUM_MOD)) dscg_checker_i (.I_CLK(I_CLK), .I_RESET(I_RESET),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .O_PREADY(O_PREADY),
  .O_PRDATA(O_PRDATA), .O_PSLVERR(O_PSLVERR), .I_SLEEP(I_SLEEP), .I_DEEP_SLEEP(I_DEEP_SLEEP),
  .I_MODULE_ACCESS(I_MODULE_ACCESS), .O_BUS_FAULT(O_BUS_FAULT), .O_CLK_EN(O_CLK_EN), .O_MODULE_EN(O_MODULE_EN));

// >>> dscg_periph_model.sv
// Processor-side access model for the gated modules
`timescale 1ns/1ps
module dscg_periph_model (
  // Requests and enables
  input  wire logic [7:0] i_try,
  input  wire logic       i_allow_fault,
  input  wire logic [7:0] i_clk_en,
  // Access strobes
  output logic      [7:0] o_access
);
  // Careful software touches only clocked modules; fault tests override
  assign o_access = i_allow_fault ? i_try : (i_try & i_clk_en);
endmodule

// >>> tb_top.sv
// Self-checking bench for the clock gating block
`timescale 1ns/1ps
module tb_top;
  logic        clk, rst, psel, pen, pwr, slp, dslp, allow, ready, err, fault, rerr;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, rd;
  logic [7:0]  try, acc, clk_en, mod_en;
  int          n_mismatch, total_checks;
  int          bits [8] = '{0, 1, 4, 12, 16, 17, 18, 24};
  dscg_top dscg_top_i (.I_CLK(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(addr), .I_PWDATA(wdata), .O_PREADY(ready), .O_PRDATA(rdata), .O_PSLVERR(err),
    .I_SLEEP(slp), .I_DEEP_SLEEP(dslp), .I_MODULE_ACCESS(acc), .O_BUS_FAULT(fault),
    .O_CLK_EN(clk_en), .O_MODULE_EN(mod_en));
  dscg_periph_model dscg_periph_model_i (.i_try(try), .i_allow_fault(allow), .i_clk_en(clk_en), .o_access(acc));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel  <= 1'b1;
    pen   <= 1'b0;
    pwr   <= w;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (ready !== 1'b1);
    rd   = rdata;
    rerr = err;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  // Fault shows one cycle after the access cycle
  task automatic poke(input logic [7:0] m, input logic f, input logic exp);
    try   <= m;
    allow <= f;
    @(posedge clk);
    try <= 8'h00;
    @(posedge clk);
    chk({31'h0, fault}, {31'h0, exp});
  endtask
  task automatic en_is(input logic [7:0] exp);
    repeat (2) @(posedge clk);
    chk({24'h0, clk_en}, {24'h0, exp});
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #100us;
    n_mismatch++;
    finish_test;
  end
  initial
  begin
    rst = 1'b1;
    {psel, pen, pwr, slp, dslp, allow} = '0;
    addr = '0;
    wdata = '0;
    try = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (bits[k])
    begin
      apb(1'b0, 12'h060 + 12'(k % 4) * 12'h010 + (k % 4 > 0 ? 12'h094 : 12'h0), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b1, 12'h124, 32'hFFFF_FFFF);
    apb(1'b0, 12'h124, 32'h0);
    chk(rd, 32'h0107_1013);
    chk({31'h0, rerr}, 32'h0);
    apb(1'b1, 12'h124, 32'h0);
    apb(1'b0, 12'h200, 32'h0);
    chk({rerr, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, 12'h128, 32'h1);
    chk({31'h0, rerr}, 32'h1);
    dslp <= 1'b1;
    apb(1'b1, 12'h104, 32'h0100_0000);
    en_is(8'h80);
    poke(8'h01, 1'b1, 1'b1);
    poke(8'h80, 1'b1, 1'b0);
    apb(1'b1, 12'h060, 32'h1);
    en_is(8'h00);
    poke(8'h01, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, 12'h124, 32'h0);
      apb(1'b1, 12'h124, rd | (32'h1 << bits[i]));
      en_is(8'((16'h2 << i) - 16'h1));
      chk({24'h0, mod_en}, {24'h0, clk_en});
    end
    apb(1'b1, 12'h114, 32'h0000_0013);
    dslp <= 1'b0;
    slp  <= 1'b1;
    en_is(8'h07);
    poke(8'h08, 1'b1, 1'b1);
    apb(1'b0, 12'h128, 32'h0);
    chk(rd, 32'h4000_0013);
    slp <= 1'b0;
    en_is(8'h80);
    apb(1'b0, 12'h128, 32'h0);
    chk(rd, 32'h0100_0000);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 12'h124, 32'h0);
    chk(rd, 32'h0);
    finish_test;
  end
endmodule
